//--- bench/host_model.sv
`timescale 1ns/100ps
module host_model (
    // clock and read data
    input  wire       clock,
    input  wire [7:0] regRdData_q,
    // register requests
    output reg  [7:0] regAddr,
    output reg  [7:0] regWrData,
    output reg        regWrite,
    output reg        regRead
);
    // idle port
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // one byte write, released lines show inverted values
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock);
            regAddr = a;
            regWrData = d;
            regWrite = 1'b1;
            @(negedge clock);
            regWrite = 1'b0;
            regAddr = ~a;
            regWrData = ~d;
        end
    endtask

    // one byte read, data taken after the sampling edge
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clock);
            regAddr = a;
            regRead = 1'b1;
            @(negedge clock);
            regRead = 1'b0;
            regAddr = ~a;
            d = regRdData_q;
        end
    endtask
endmodule

//--- bench/monitor_flags_sva.sv
`timescale 1ns/100ps
module monitor_flags_sva #(
    parameter NCH = 5,
    parameter W   = 16
) (
    // clock and reset
    input wire             clock,
    input wire             reset,
    // block inputs
    input wire [NCH-1:0]   convDone,
    input wire [NCH*W-1:0] convResult,
    input wire [NCH*W-1:0] limitHighBytes,
    input wire [NCH*W-1:0] limitLowBytes,
    input wire [15:0]      alarmMask,
    input wire [7:0]       regAddr,
    input wire [7:0]       regWrData,
    input wire             regWrite,
    input wire             regRead,
    // block outputs
    input wire [7:0]       regRdData_q,
    input wire [NCH-1:0]   updateFlags,
    input wire [15:0]      alarmFlags,
    input wire             maskedInterruptFlag
);
    // register views of the update flags
    wire [4:0] keepMask = {regWrData[3], regWrData[4], regWrData[5], regWrData[6], regWrData[7]};
    wire [7:0] updByte  = {updateFlags[0], updateFlags[1], updateFlags[2], updateFlags[3],
                           updateFlags[4], 3'h0};
    wire       updWr    = regWrite && regAddr == 8'h6f;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    upd_set_a: assert property (|convDone |=>
        (updateFlags & $past(convDone)) == $past(convDone)) else $error("update flag not set");
    upd_hold_a: assert property (!updWr |=>
        (updateFlags & $past(updateFlags)) == $past(updateFlags)) else $error("update flag lost");
    upd_clear_a: assert property (updWr && convDone == 0 |=>
        updateFlags == ($past(updateFlags) & $past(keepMask))) else $error("bad clear");
    upd_cause_a: assert property (
        (updateFlags & ~$past(updateFlags) & ~$past(convDone)) == 0) else $error("stray set");
    rd_update_a: assert property (regRead && regAddr == 8'h6f |=>
        regRdData_q == $past(updByte)) else $error("update read wrong");
    rd_alarm_a: assert property (regRead && regAddr == 8'h70 |=>
        regRdData_q == $past(alarmFlags[15:8])) else $error("alarm read wrong");
    rd_alarm2_a: assert property (regRead && regAddr == 8'h71 |=>
        regRdData_q == $past(alarmFlags[7:0])) else $error("alarm2 read wrong");
    masked_interrupt_flag_a: assert property (alarmFlags[5:0] == {5'h00, maskedInterruptFlag} &&
        maskedInterruptFlag == |(alarmFlags[15:6] & alarmMask[15:6])) else $error("bad masked_interrupt_flag");
    temp_high_a: assert property (convDone[0] |=> alarmFlags[15] ==
        ($signed($past(convResult[15:0])) > $signed($past(limitHighBytes[15:0]))))
        else $error("temp high wrong");
    supply_low_a: assert property (convDone[1] |=> alarmFlags[12] ==
        ($past(convResult[31:16]) < $past(limitLowBytes[31:16]))) else $error("supply low wrong");
    alarm_hold_a: assert property (convDone == 0 |=>
        $stable(alarmFlags[15:6])) else $error("alarm moved");
endmodule

bind monitor_update_alarm_flags monitor_flags_sva #(.NCH(NCH), .W(W)) sva_i (
    .clock(clock), .reset(reset), .convDone(convDone), .convResult(convResult),
    .limitHighBytes(limitHighBytes), .limitLowBytes(limitLowBytes), .alarmMask(alarmMask),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_q(regRdData_q), .updateFlags(updateFlags), .alarmFlags(alarmFlags),
    .maskedInterruptFlag(maskedInterruptFlag));

//--- bench/tb_monitor_update_alarm_flags.sv
`timescale 1ns/100ps
module tb_monitor_update_alarm_flags;
    reg  [4:0]  convDone;
    reg  [79:0] convResult;
    reg  [79:0] limitHighBytes;
    reg  [79:0] limitLowBytes;
    reg  [15:0] alarmMask;
    reg         clock;
    reg         reset;
    reg  [7:0]  rdv;
    wire [7:0]  regAddr;
    wire [7:0]  regWrData;
    wire        regWrite;
    wire        regRead;
    wire [7:0]  regRdData_q;
    wire [4:0]  updateFlags;
    wire [15:0] alarmFlags;
    wire        maskedInterruptFlag;
    integer     mismatches;
    integer     checked;
    integer     k;

    monitor_update_alarm_flags monitor_update_alarm_flags_i (.clock(clock), .reset(reset),
        .convDone(convDone), .convResult(convResult), .limitHighBytes(limitHighBytes),
        .limitLowBytes(limitLowBytes), .alarmMask(alarmMask), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData_q(regRdData_q), .updateFlags(updateFlags), .alarmFlags(alarmFlags),
        .maskedInterruptFlag(maskedInterruptFlag));
    host_model host_model_i (.clock(clock), .regRdData_q(regRdData_q), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));

    // clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task chk(input string nm, input [7:0] ex, input [7:0] got);
        begin
            checked = checked + 1;
            if (got !== ex) begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask

    task pulse(input [4:0] m);
        begin
            @(negedge clock);
            convDone = m;
            @(negedge clock);
            convDone = 5'h00;
        end
    endtask

    task rdchk(input string nm, input [7:0] a, input [7:0] ex);
        begin
            host_model_i.rd(a, rdv);
            chk(nm, ex, rdv);
        end
    endtask

    // reset held for eight cycles, then the update flags and the primary alarm byte must read back cleared
    task t_reset;
        begin
            reset = 1'b1;
            repeat (8) @(negedge clock);
            reset = 1'b0;
            rdchk("reset", 8'h6f, 8'h00);
            rdchk("resetalarm", 8'h70, 8'h00);
            $display("test reset done");
        end
    endtask

    task t_updates;
        begin
            for (k = 0; k < 5; k = k + 1) begin
                host_model_i.wr(8'h6f, 8'h00);
                pulse(5'h01 << k);
                rdchk("update", 8'h6f, 8'h80 >> k);
                host_model_i.wr(8'h6f, 8'hff);
                rdchk("kept", 8'h6f, 8'h80 >> k);
            end
            pulse(5'h1f);
            chk("flagpins", 8'h1f, {3'h0, updateFlags});
            rdchk("all", 8'h6f, 8'hf8);
            host_model_i.wr(8'h6f, 8'h07);
            rdchk("cleared", 8'h6f, 8'h00);
            $display("test updates done");
        end
    endtask

    task t_alarms;
        begin
            limitHighBytes = {5{16'h1000}};
            limitLowBytes = {5{16'h0100}};
            convResult = {16'h0050, 16'h2000, 16'h0050, 16'h2000, 16'h8000};
            pulse(5'h1f);
            rdchk("primary", 8'h70, 8'h66);
            rdchk("secondary", 8'h71, 8'h40);
            alarmMask = 16'h4000;
            rdchk("masked_interrupt_flag", 8'h71, 8'h41);
            chk("mintpin", 8'h01, {7'h00, maskedInterruptFlag});
            chk("alarmlow", 8'h41, alarmFlags[7:0]);
            chk("alarmhigh", 8'h66, alarmFlags[15:8]);
            host_model_i.wr(8'h70, 8'hff);
            convResult = {5{16'h0800}};
            rdchk("held", 8'h70, 8'h66);
            rdchk("unmapped", 8'h72, 8'h00);
            pulse(5'h1f);
            rdchk("clear", 8'h70, 8'h00);
            rdchk("clear2", 8'h71, 8'h00);
            convResult[15:0] = 16'h7fff;
            pulse(5'h01);
            rdchk("temphigh", 8'h70, 8'h80);
            rdchk("meastemp", 8'h60, 8'h7f);
            rdchk("meastemplo", 8'h61, 8'hff);
            rdchk("measin3", 8'h68, 8'h08);
            $display("test alarms done");
        end
    endtask

    task end_of_test;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // watchdog
    initial begin
        #20000;
        mismatches = mismatches + 1;
        end_of_test;
    end

    // main sequence
    initial begin
        mismatches = 0;
        checked = 0;
        reset = 1'b1;
        convDone = 5'h00;
        convResult = {5{16'h0000}};
        limitHighBytes = {5{16'h0000}};
        limitLowBytes = {5{16'h0000}};
        alarmMask = 16'h0000;
        t_reset;
        t_updates;
        t_alarms;
        t_reset;
        end_of_test;
    end
endmodule

//--- hdl/channel_alarm_compare.v
`timescale 1ns/100ps
`include "monitor_flags_consts.vh"

module channel_alarm_compare #(
    parameter W         = 16,
    parameter SIGNEDCMP = 0
) (
    // clock and reset
    input  wire         clock,
    input  wire         reset,
    // new result and its limits
    input  wire         resultStore,
    input  wire [W-1:0] result,
    input  wire [W-1:0] limitHigh,
    input  wire [W-1:0] limitLow,
    // alarm levels
    output reg          highAlarm_q,
    output reg          lowAlarm_q
);

    wire aboveHigh;
    wire belowLow;

    // two's complement compare for signed channels, plain otherwise
    assign aboveHigh = SIGNEDCMP ? ($signed(result) > $signed(limitHigh)) : (result > limitHigh);
    assign belowLow  = SIGNEDCMP ? ($signed(result) < $signed(limitLow)) : (result < limitLow);

    // flags re-evaluated only when a result is stored
    always @(posedge clock) begin
        if (reset) begin
            highAlarm_q <= `ALARM_RESET;
            lowAlarm_q  <= `ALARM_RESET;
        end else if (resultStore) begin
            highAlarm_q <= aboveHigh;
            lowAlarm_q  <= belowLow;
        end
    end

endmodule

//--- hdl/monitor_flags_consts.vh
`ifndef MONITOR_FLAGS_CONSTS_VH
`define MONITOR_FLAGS_CONSTS_VH

// register offsets on the internal byte port
`define OFS_MEAS_FIRST      8'h60
`define OFS_MEAS_LAST       8'h69
`define OFS_CONV_UPDATE     8'h6f
`define OFS_ALARM_PRIMARY   8'h70
`define OFS_ALARM_SECONDARY 8'h71

// conversion-update register layout
`define UPD_TEMP_BIT        7
`define UPD_SUPPLY_BIT      6
`define UPD_INPUT1_BIT      5
`define UPD_INPUT2_BIT      4
`define UPD_INPUT3_BIT      3
`define UPD_LOW_BIT         3
`define UPD_RESET           5'h00

// alarm layout in the 16-bit primary:secondary view
`define ALARM_HIGH_TOP      15
`define ALARM_LOW_TOP       14
`define ALARM_USED_LOW      6
`define ALARM_MASKED_INTERRUPT_FLAG_BIT      0
`define ALARM_RESET         1'h0

// channel numbering
`define CH_TEMP             0
`define CH_SUPPLY           1
`define CH_INPUT1           2
`define CH_INPUT2           3
`define CH_INPUT3           4

// misc constants
`define BYTE_ZERO           8'h00
`define WORD_ZERO           16'h0000

`endif

//--- hdl/monitor_update_alarm_flags.v
// Behaviour
// - a stored temperature result sets the temperature update bit, bit 7 of the update register.
// - each update bit stays set until the host writes 0 to it, so the host can clear and poll.
// - a stored supply result sets the supply update bit, bit 6.
// - a stored first input result sets the input-one update bit, bit 5.
// - a stored second input result sets the input-two update bit, bit 4.
// - a stored third input result sets the input-three update bit, bit 3.
// - bit 7 of the primary alarm register shows the temperature above its upper limit.
// - bit 6 of the primary alarm register shows the temperature below its lower limit.
// - bits 5 and 4 of the primary alarm register show supply above and below its limits.
// - bits 3 and 2 of the primary alarm register show input one above and below its limits.
// - bits 1 and 0 of the primary alarm register show input two above and below its limits.
// - bits 7 and 6 of the secondary alarm register show input three above and below its limits.
// - limits are two-byte nonvolatile fields, most significant byte first, a pair per channel.
// - bit 0 of the secondary alarm register is the alarm flags gated by a mask, zero mask gives 0.
`timescale 1ns/100ps
`include "monitor_flags_consts.vh"

module monitor_update_alarm_flags #(
    parameter NCH = 5,
    parameter W   = 16
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset,
    // converter results, channel 0 temperature, 1 supply, 2..4 inputs
    input  wire [NCH-1:0]   convDone,
    input  wire [NCH*W-1:0] convResult,
    // nonvolatile limits, msb byte then lsb byte per channel
    input  wire [NCH*W-1:0] limitHighBytes,
    input  wire [NCH*W-1:0] limitLowBytes,
    // flag mask, same layout as primary:secondary alarm bytes
    input  wire [15:0]      alarmMask,
    // byte register port from the serial engine
    input  wire [7:0]       regAddr,
    input  wire [7:0]       regWrData,
    input  wire             regWrite,
    input  wire             regRead,
    output reg  [7:0]       regRdData_q,
    // status outputs
    output wire [NCH-1:0]   updateFlags,
    output wire [15:0]      alarmFlags,
    output wire             maskedInterruptFlag
);

    // stored results
    reg  [W-1:0]   measured_q [0:NCH-1];

    // per-channel alarm levels
    wire [NCH-1:0] highAlarm;
    wire [NCH-1:0] lowAlarm;

    // update flag plumbing, index 0 is the temperature bit
    wire [NCH-1:0] updateSet;
    wire [NCH-1:0] updateClear;
    wire [NCH-1:0] updateQ;
    wire           updateWrite;

    // assembled register views
    wire [7:0]     conversionUpdateFlags;
    wire [7:0]     alarmFlagsPrimary;
    wire [7:0]     alarmFlagsSecondary;
    wire [15:0]    alarmRaw;
    wire [15:0]    alarmUsed;
    reg  [7:0]     readData_d;

    // measured-value byte select
    wire [7:0]     measOffset;
    wire [2:0]     measIndex;
    wire           measLowByte;
    wire           measHit;
    reg  [W-1:0]   measWord;

    integer k;

    // result storage: a new conversion overwrites its byte pair
    always @(posedge clock) begin
        if (reset) begin
            for (k = 0; k < NCH; k = k + 1) begin
                measured_q[k] <= `WORD_ZERO;
            end
        end else begin
            for (k = 0; k < NCH; k = k + 1) begin
                if (convDone[k]) begin
                    measured_q[k] <= convResult[k*W +: W];
                end
            end
        end
    end

    // host write to the update register clears bits written as 0
    assign updateWrite = regWrite && (regAddr == `OFS_CONV_UPDATE);

    // per-channel compare and flag wiring
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            // flag sets in the same edge that stores the result
            assign updateSet[i]   = convDone[i];
            // write of 0 clears; bits below the used field never decode
            assign updateClear[i] = updateWrite &
                                    ~regWrData[`UPD_TEMP_BIT - i];

            // threshold compare on each stored result
            channel_alarm_compare #(
                .W         (W),
                .SIGNEDCMP ((i == `CH_TEMP) ? 1 : 0)
            ) u_cmp (
                .clock       (clock),
                .reset       (reset),
                .resultStore (convDone[i]),
                .result      (convResult[i*W +: W]),
                .limitHigh   (limitHighBytes[i*W +: W]),
                .limitLow    (limitLowBytes[i*W +: W]),
                .highAlarm_q (highAlarm[i]),
                .lowAlarm_q  (lowAlarm[i])
            );

            // high then low, channel by channel from the top of the word
            assign alarmRaw[`ALARM_HIGH_TOP - 2*i] = highAlarm[i];
            assign alarmRaw[`ALARM_LOW_TOP - 2*i]  = lowAlarm[i];
        end
    endgenerate

    // unused low positions of the alarm word stay 0
    assign alarmRaw[`ALARM_USED_LOW-1:0] = {`ALARM_USED_LOW{1'b0}};

    // sticky update bits
    update_flag_bank #(
        .N (NCH)
    ) u_upd (
        .clock    (clock),
        .reset    (reset),
        .setPulse (updateSet),
        .clearReq (updateClear),
        .flags_q  (updateQ)
    );

    // update register: channel 0 lands on bit 7, unused bits read 0
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_upd
            assign conversionUpdateFlags[`UPD_TEMP_BIT - i] = updateQ[i];
        end
    endgenerate
    assign conversionUpdateFlags[`UPD_LOW_BIT-1:0] = {`UPD_LOW_BIT{1'b0}};

    // masked interrupt over the used alarm positions only
    assign alarmUsed           = alarmRaw & alarmMask;
    assign maskedInterruptFlag = |alarmUsed[15:`ALARM_USED_LOW];

    // alarm register views, read only
    assign alarmFlagsPrimary   = alarmRaw[15:8];
    assign alarmFlagsSecondary = {alarmRaw[7:1], maskedInterruptFlag};

    // status outputs
    assign updateFlags = updateQ;
    assign alarmFlags  = {alarmFlagsPrimary, alarmFlagsSecondary};

    // measured byte pair decode, msb at the even offset
    assign measOffset  = regAddr - `OFS_MEAS_FIRST;
    assign measIndex   = measOffset[3:1];
    assign measLowByte = measOffset[0];
    assign measHit     = (regAddr >= `OFS_MEAS_FIRST) && (regAddr <= `OFS_MEAS_LAST);

    // select the stored word for a measured-value read
    always @* begin
        measWord = `WORD_ZERO;
        case (measIndex)
            3'h0: measWord = measured_q[`CH_TEMP];
            3'h1: measWord = measured_q[`CH_SUPPLY];
            3'h2: measWord = measured_q[`CH_INPUT1];
            3'h3: measWord = measured_q[`CH_INPUT2];
            3'h4: measWord = measured_q[`CH_INPUT3];
            default: measWord = `WORD_ZERO;
        endcase
    end

    // read multiplexer, unmapped offsets read 0
    always @* begin
        readData_d = `BYTE_ZERO;
        if (measHit) begin
            readData_d = measLowByte ? measWord[7:0] : measWord[15:8];
        end else begin
            case (regAddr)
                `OFS_CONV_UPDATE:     readData_d = conversionUpdateFlags;
                `OFS_ALARM_PRIMARY:   readData_d = alarmFlagsPrimary;
                `OFS_ALARM_SECONDARY: readData_d = alarmFlagsSecondary;
                default:              readData_d = `BYTE_ZERO;
            endcase
        end
    end

    // read data captured one edge after the read strobe
    always @(posedge clock) begin
        if (reset) begin
            regRdData_q <= `BYTE_ZERO;
        end else if (regRead) begin
            regRdData_q <= readData_d;
        end
    end

endmodule

//--- hdl/update_flag_bank.v
`timescale 1ns/100ps
`include "monitor_flags_consts.vh"

module update_flag_bank #(
    parameter N = 5
) (
    // clock and reset
    input  wire         clock,
    input  wire         reset,
    // events and clears
    input  wire [N-1:0] setPulse,
    input  wire [N-1:0] clearReq,
    // sticky flags
    output reg  [N-1:0] flags_q
);

    wire [N-1:0] flags_d;

    // sticky bits: a set in the cycle of a clear wins
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            assign flags_d[i] = setPulse[i] | (flags_q[i] & ~clearReq[i]);
        end
    endgenerate

    // flag storage
    always @(posedge clock) begin
        if (reset) begin
            flags_q <= {N{1'b0}};
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule
